// [baud_tick.sv]
// selectable clock source tick generator for the baud timer
`timescale 1ns/100ps
`include "uart_defines.svh"
module baud_tick (
   // clock and control
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   // source selection and synchronised slow sources
   input  wire logic [2:0] i_sel,
   input  wire logic       i_extosc_sync,
   input  wire logic       i_extpin_sync,
   // one-cycle count enable for the timer
   output logic            o_tick
);
   // all state in one struct
   typedef struct packed {
      logic [5:0] pre;
      logic [2:0] osc_cnt;
      logic       osc_d;
      logic       pin_d;
      logic       tick;
   } st_type;
   st_type st;
   st_type next_st;
   // count prescaler, edges of the slow sources
   always_comb begin
      logic [5:0] lim;
      lim = 6'h00;
      next_st = st;
      next_st.osc_d = i_extosc_sync;
      next_st.pin_d = i_extpin_sync;
      next_st.pre = (st.pre >= `PRESCALE_MAX) ? 6'h00 : st.pre + 6'h01;
      if (i_extosc_sync && !st.osc_d) begin
         next_st.osc_cnt = st.osc_cnt + 3'h1;
      end
      // source choice, ticks of the prescaled system clock
      case (i_sel)
         `SRC_DIV1:    lim = 6'h00;
         `SRC_DIV4:    lim = 6'h03;
         `SRC_DIV12:   lim = 6'h0b;
         default:      lim = 6'h2f;
      endcase
      if (i_sel == `SRC_DIV1) begin
         next_st.tick = 1'b1;
      end else if (i_sel == `SRC_EXTOSC8) begin
         next_st.tick = i_extosc_sync && !st.osc_d && (st.osc_cnt == 3'h7);
      end else if (i_sel == `SRC_EXTPIN) begin
         next_st.tick = !i_extpin_sync && st.pin_d;
      end else begin
         next_st.tick = ((st.pre % (lim + 6'h01)) == 6'h00);
      end
   end
   // register the state
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end
   assign o_tick = st.tick;
endmodule

// [tb_uart_serial_port.sv]
// self-checking bench: register port, transmit frames, receive acceptance cases
`timescale 1ns/100ps
`include "uart_defines.svh"
module tb_uart_serial_port;
   // clock, reset and register port drives
   logic        mclk, sys_rst, wr, rd, irq_en, serial_out, irq, rx_line, ext_clk;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata;
   // counters and captured frame
   int          fail_count, samples_checked, cycles;
   logic [10:0] frame;
   logic [1:0]  flags;
   // transmit configs: reload, source, bit length in clocks
   logic [7:0]  cf_rel [6] = '{8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfc};
   logic [2:0]  cf_src [6] = '{`SRC_DIV4, `SRC_DIV48, `SRC_EXTOSC8, `SRC_EXTPIN,
                               `SRC_DIV12, `SRC_DIV1};
   int          cf_len [6] = '{16, 96, 32, 4, 24, 8};
   // receive cases: control, bits, count, stop level, expected control and data
   logic [7:0]  rx_ctl [8] = '{8'h00, 8'h10, 8'h11, 8'h30, 8'h30, 8'hb0, 8'hb0, 8'h90};
   logic [8:0]  rx_bit [8] = '{9'h05a, 9'h05a, 9'h033, 9'h077, 9'h077, 9'h012, 9'h112, 9'h09c};
   int          rx_n   [8] = '{8, 8, 8, 8, 8, 9, 9, 9};
   logic        rx_stp [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0]  rx_ect [8] = '{8'h40, 8'h55, 8'h55, 8'h70, 8'h75, 8'hf0, 8'hf5, 8'hd1};
   logic [7:0]  rx_edt [8] = '{8'h00, 8'h5a, 8'h5a, 8'h5a, 8'h77, 8'h77, 8'h12, 8'h9c};

   ////////////////////////////////////////////////////////////////////////////////
   // design and remote model
   uart_serial_port uart_serial_port_inst (
      .I_MCLK(mclk), .I_SYS_RST(sys_rst), .i_CE(1'b1), .i_ADDR(addr), .i_WDATA(wdata),
      .i_WR(wr), .i_RD(rd), .o_RDATA(rdata), .i_SERIAL_IN(rx_line), .i_EXT_OSC(ext_clk),
      .i_EXT_TIMER_INPUT(ext_clk), .i_IRQ_ENABLE(irq_en), .o_SERIAL_OUT(serial_out),
      .o_IRQ(irq));
   uart_remote uart_remote_inst (.i_clk(mclk), .i_line(serial_out), .i_flag(irq),
      .o_line(rx_line));

   ////////////////////////////////////////////////////////////////////////////////
   // 25 MHz clock and a cycle ceiling against hangs
   always #20 mclk = ~mclk;
   // slow source of two clock periods for the oscillator and timer pin inputs
   always @(posedge mclk) ext_clk <= ~ext_clk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare, register access and verdict tasks
   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      check(11'(rdata), 11'(exp));
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      {wr, rd, irq_en, ext_clk, addr, wdata} = '0;
      {fail_count, samples_checked, cycles} = '0;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      // reset values, unused bit, unmapped place
      rd_reg(`ADDR_CONTROL, 8'h40);
      wr_reg(`ADDR_CONTROL, 8'h00);
      rd_reg(`ADDR_CONTROL, 8'h40);
      rd_reg(4'hf, 8'h00);
      rd_reg(`ADDR_DATA, 8'h00);
      $display("test registers done");
      // 8-bit transmit across timer sources and reload values
      @(posedge mclk);
      irq_en <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         wr_reg(`ADDR_RELOAD, cf_rel[k]);
         wr_reg(`ADDR_BAUD_CTRL, {4'h0, 1'b1, cf_src[k]});
         fork
            wr_reg(`ADDR_DATA, 8'ha5);
            uart_remote_inst.capture(8, cf_len[k], frame, flags);
         join
         check(frame, {1'b1, 1'b1, 1'b1, 8'ha5, 1'b0});
         check(11'(flags), 11'h2);
         rd_reg(`ADDR_DATA, 8'h00);
         rd_reg(`ADDR_CONTROL, 8'h42);
         rd_reg(`ADDR_CONTROL, 8'h42);
         wr_reg(`ADDR_CONTROL, 8'h00);
         rd_reg(`ADDR_CONTROL, 8'h40);
      end
      $display("test transmit 8-bit done");
      // 9-bit transmit with both ninth-bit values
      for (int k = 0; k < 2; k++) begin
         wr_reg(`ADDR_CONTROL, {4'h8, k[0], 3'h0});
         fork
            wr_reg(`ADDR_DATA, 8'h3c);
            uart_remote_inst.capture(9, 8, frame, flags);
         join
         check(frame, {1'b1, k[0], 8'h3c, 1'b0});
         check(11'(flags), 11'h2);
      end
      wr_reg(`ADDR_CONTROL, 8'h00);
      $display("test transmit 9-bit done");
      // receive acceptance, overrun and address filtering cases
      for (int k = 0; k < 8; k++) begin
         if (k != 2) wr_reg(`ADDR_CONTROL, rx_ctl[k]);
         uart_remote_inst.send(rx_bit[k], rx_n[k], rx_stp[k], 8);
         rd_reg(`ADDR_CONTROL, rx_ect[k]);
         rd_reg(`ADDR_DATA, rx_edt[k]);
         check(11'(irq), 11'(rx_ect[k][0]));
      end
      // rx done still stands: no request while the interrupt is disabled
      @(posedge mclk);
      irq_en <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check(11'(irq), 11'h0);
      $display("test receive done");
      conclude();
   end
endmodule

// [uart_defines.svh]
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH
// register indices on the plain register port
`define ADDR_CONTROL     4'h0
`define ADDR_DATA        4'h1
`define ADDR_BAUD_CTRL   4'h2
`define ADDR_RELOAD      4'h3
`define ADDR_TIMER_LOW   4'h4
// control register fields
`define BIT_MODE         7
`define BIT_UNUSED       6
`define BIT_MCE          5
`define BIT_REN          4
`define BIT_TB8          3
`define BIT_RB8          2
`define BIT_TI           1
`define BIT_RI           0
`define CONTROL_RESET    8'h40
// baud control register: bit 3 runs the timer, bits 2:0 pick the source
`define BIT_TIMER_RUN    3
`define SRC_DIV1         3'h0
`define SRC_DIV4         3'h1
`define SRC_DIV12        3'h2
`define SRC_DIV48        3'h3
`define SRC_EXTOSC8      3'h4
`define SRC_EXTPIN       3'h5
// timer overflow count per bit, frame lengths in bits and prescaler top count
`define OVF_PER_BIT      5'h02
`define BITS_8BIT        4'ha
`define BITS_9BIT        4'hb
`define PRESCALE_MAX     6'h2f
`endif

// [uart_pkg.sv]
// types shared by the serial port files
package uart_pkg;
   // register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_type;
   // transmitter and receiver states
   typedef enum logic [1:0] {IDLE, SHIFT} tx_state_type;
   typedef enum logic [1:0] {R_IDLE, R_START, R_DATA} rx_state_type;
endpackage

// [uart_remote.sv]
// remote serial transceiver model standing on the port's transmit and receive lines
`timescale 1ns/100ps
module uart_remote (
   // clock shared with the port
   input  wire logic i_clk,
   // line from the port and its interrupt level
   input  wire logic i_line,
   input  wire logic i_flag,
   // line into the port
   output logic      o_line
);
   ////////////////////////////////////////////////////////////////////////////////
   // the line idles high outside frames
   initial o_line = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // send one frame: start, data lsb first, given stop level, then one idle bit
   task automatic send(input logic [8:0] bits, input int nbits, input logic stop,
                       input int bitlen);
      // launch the start bit just after a rising edge
      @(posedge i_clk);
      o_line <= 1'b0;
      repeat (bitlen) @(posedge i_clk);
      for (int i = 0; i < nbits; i++) begin
         o_line <= bits[i];
         repeat (bitlen) @(posedge i_clk);
      end
      o_line <= stop;
      repeat (bitlen) @(posedge i_clk);
      o_line <= 1'b1;
      repeat (bitlen) @(posedge i_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // capture one frame mid-bit; flag seen mid last data bit and mid stop bit
   task automatic capture(input int nbits, input int bitlen, output logic [10:0] bits,
                          output logic [1:0] flag);
      int n;
      n = 0;
      bits = '1;
      flag = 2'h3;
      // falling edge on the idle-high line marks the start bit
      while (i_line !== 1'b0 && n < 4000) begin
         @(negedge i_clk);
         n++;
      end
      repeat (bitlen / 2) @(negedge i_clk);
      for (int i = 0; i < nbits + 2; i++) begin
         bits[i] = i_line;
         if (i == nbits) flag[0] = i_flag;
         if (i == nbits + 1) flag[1] = i_flag;
         if (i < nbits + 1) repeat (bitlen) @(negedge i_clk);
      end
   endtask
endmodule

// [uart_serial_port.sv]
// asynchronous serial port with baud timer and register port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "uart_defines.svh"
// Functional notes
// R1: 8-bit frame: start, 8 data lsb-first, stop
// R2: 9-bit frame adds programmable ninth bit
// R3: control bit 7 selects 8/9-bit framing
// R4: data write loads and starts transmission
// R5: data read returns receive buffer only
// R6: tx done set at stop-bit start
// R7: receive only when receive enable is 1
// R8: 8-bit accept: flag clear, stop ok
// R9: failed acceptance changes nothing
// R10: overrun keeps first byte, drops new
// R11: 9-bit accept: flag clear, ninth ok
// R12: 9-bit transmit sends tx ninth bit
// R13: interrupt raised when either done flag set
// R14: flags cleared only by software
// R15: receive next while buffer unread
// R16: tx/rx clocks are overflows divided by two
// R17: rx counter reloaded on start detection
// R18: overflow rate = clock / (256 - reload)
// R19: software uses auto-reload at 2x baud
// R20: six selectable timer clock sources
// R21: master sets ninth bit for addresses
// R22: control bit 6 reads one, ignores writes
// R23: rx done set at stop sampling
// R24: lines idle high, mid-bit sampling
module uart_serial_port (
   // clock, reset, enable
   input  wire logic       I_MCLK,
   input  wire logic       I_SYS_RST,
   input  wire logic       i_CE,
   // register port
   input  wire logic [3:0] i_ADDR,
   input  wire logic [7:0] i_WDATA,
   input  wire logic       i_WR,
   input  wire logic       i_RD,
   output logic      [7:0] o_RDATA,
   // serial pins and timer sources
   input  wire logic       i_SERIAL_IN,
   input  wire logic       i_EXT_OSC,
   input  wire logic       i_EXT_TIMER_INPUT,
   input  wire logic       i_IRQ_ENABLE,
   output logic            o_SERIAL_OUT,
   output logic            o_IRQ
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [1:0]              rx_sync;  // serial input synchroniser
      logic [1:0]              osc_sync; // external oscillator synchroniser
      logic [1:0]              pin_sync; // external timer pin synchroniser
      logic [7:0]              control;  // control register
      logic [7:0]              rx_buf;   // buffered receive byte
      logic [7:0]              reload;   // reload byte
      logic [3:0]              baud;     // timer run and source select
      logic [7:0]              tl;       // transmit timer low byte
      logic [7:0]              rxt;      // hidden receive timer
      logic                    tx_half;  // overflow divide by two, transmit
      logic [4:0]              rx_ovf;   // overflows into current rx bit
      uart_pkg::tx_state_type  tx_st;
      logic [9:0]              tx_sh;    // data and ninth bit to send
      logic [3:0]              tx_bit;   // bits sent including start
      uart_pkg::rx_state_type  rx_st;
      logic [8:0]              rx_sh;    // incoming data and ninth bit
      logic [3:0]              rx_bit;
      logic                    rx_prev;  // previous synchronised line level
      logic                    out;
      logic [7:0]              rdata;
      logic                    irq;
   } st_type;
   st_type st;
   st_type next_st;
   logic   tick;
   ////////////////////////////////////////////////////////////////////////////
   // timer clock source selection [R20]
   baud_tick u_tick (
      .i_clk         (I_MCLK),
      .i_rst         (I_SYS_RST),
      .i_ce          (i_CE),
      .i_sel         (st.baud[2:0]),
      .i_extosc_sync (st.osc_sync[1]),
      .i_extpin_sync (st.pin_sync[1]),
      .o_tick        (tick)
   );
   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic       run;
      logic       tx_ovf;
      logic       rx_ovf;
      logic       rx_line;
      logic       nine;
      logic [3:0] nbits;
      logic       bitclk;
      logic       sample;
      logic       accept;
      run     = 1'b0;
      tx_ovf  = 1'b0;
      rx_ovf  = 1'b0;
      rx_line = 1'b1;
      nine    = 1'b0;
      nbits   = 4'h0;
      bitclk  = 1'b0;
      sample  = 1'b0;
      accept  = 1'b0;
      next_st = st;
      // two-stage synchronisers on pins
      next_st.rx_sync  = {st.rx_sync[0], i_SERIAL_IN};
      next_st.osc_sync = {st.osc_sync[0], i_EXT_OSC};
      next_st.pin_sync = {st.pin_sync[0], i_EXT_TIMER_INPUT};
      rx_line = st.rx_sync[1];
      next_st.rx_prev = rx_line;
      nine  = st.control[`BIT_MODE]; // [R3]
      nbits = nine ? `BITS_9BIT : `BITS_8BIT; // [R1] [R2]
      run   = st.baud[`BIT_TIMER_RUN];
      // transmit timer: overflow at 256 - reload counts [R18]
      if (run && tick) begin
         if (st.tl == 8'hff) begin
            next_st.tl = st.reload;
            tx_ovf = 1'b1;
         end else begin
            next_st.tl = st.tl + 8'h01;
         end
      end
      // hidden receive timer, same reload [R17]
      if (run && tick) begin
         if (st.rxt == 8'hff) begin
            next_st.rxt = st.reload;
            rx_ovf = 1'b1;
         end else begin
            next_st.rxt = st.rxt + 8'h01;
         end
      end
      // transmit bit clock: every second overflow [R16]
      if (tx_ovf) begin
         next_st.tx_half = ~st.tx_half;
      end
      bitclk = tx_ovf && st.tx_half;
      // transmitter
      case (st.tx_st)
         uart_pkg::IDLE: begin
            next_st.out = 1'b1; // [R24]
         end
         default: begin
            if (bitclk) begin
               if (st.tx_bit == 4'h0) begin
                  next_st.out = 1'b0;
               end else if (st.tx_bit < nbits - 4'h1) begin
                  next_st.out = st.tx_sh[0]; // lsb first [R1] [R2] [R12]
                  next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
               end else if (st.tx_bit == nbits - 4'h1) begin
                  next_st.out = 1'b1;
                  next_st.control[`BIT_TI] = 1'b1; // stop-bit start [R6]
               end else begin
                  next_st.tx_st = uart_pkg::IDLE;
               end
               next_st.tx_bit = st.tx_bit + 4'h1;
            end
         end
      endcase
      // receiver: half bit is one overflow, whole bit two
      case (st.rx_st)
         uart_pkg::R_IDLE: begin
            if (st.control[`BIT_REN] && st.rx_prev && !rx_line) begin // [R7] [R24]
               next_st.rxt    = st.reload; // forced reload on start [R17]
               next_st.rx_ovf = 5'h00;
               next_st.rx_bit = 4'h0;
               next_st.rx_st  = uart_pkg::R_START;
            end
         end
         uart_pkg::R_START: begin
            // mid start bit check after one overflow
            if (rx_ovf) begin
               if (rx_line) begin
                  next_st.rx_st = uart_pkg::R_IDLE;
               end else begin
                  next_st.rx_st  = uart_pkg::R_DATA;
                  next_st.rx_ovf = 5'h00;
               end
            end
         end
         default: begin
            if (rx_ovf) begin
               next_st.rx_ovf = st.rx_ovf + 5'h01;
               sample = (st.rx_ovf == `OVF_PER_BIT - 5'h01); // [R16] [R24]
               if (sample) begin
                  next_st.rx_ovf = 5'h00;
                  next_st.rx_bit = st.rx_bit + 4'h1;
                  next_st.rx_sh  = {rx_line, st.rx_sh[8:1]};
               end
            end
            // stop bit sampled: decide acceptance [R23]
            if (sample && st.rx_bit == nbits - 4'h2) begin
               next_st.rx_st = uart_pkg::R_IDLE;
               // new shift runs beside unread buffer [R15]
               if (nine) begin
                  // ninth bit checked, stop ignored [R11]
                  accept = !st.control[`BIT_RI] &&
                           (!st.control[`BIT_MCE] || st.rx_sh[8]);
               end else begin
                  accept = !st.control[`BIT_RI] &&
                           (!st.control[`BIT_MCE] || rx_line); // [R8]
               end
               // overrun leaves first byte in buffer [R9] [R10]
               if (accept) begin
                  next_st.rx_buf = nine ? st.rx_sh[8:1] : st.rx_sh[8:1];
                  next_st.control[`BIT_RB8] = nine ? st.rx_sh[8] : rx_line;
                  next_st.control[`BIT_RI]  = 1'b1;
                  if (nine) begin
                     next_st.rx_buf = {st.rx_sh[7:0]};
                  end
               end
            end
         end
      endcase
      // register writes; hardware set of a flag beats software clear [R14]
      next_st.rdata = 8'h00;
      if (i_WR) begin
         if (i_ADDR == `ADDR_CONTROL) begin
            next_st.control = {i_WDATA[7], 1'b1, i_WDATA[5:0]}; // [R22]
            // a stop-bit start in this cycle sets tx done whatever is written
            next_st.control[`BIT_TI] = i_WDATA[`BIT_TI] | (bitclk &&
               st.tx_st == uart_pkg::SHIFT && st.tx_bit == nbits - 4'h1); // [R6] [R14]
            next_st.control[`BIT_RI] = i_WDATA[`BIT_RI] | accept;
            if (accept) begin
               next_st.control[`BIT_RB8] = nine ? st.rx_sh[8] : rx_line;
            end
         end else if (i_ADDR == `ADDR_DATA) begin
            // load and start at once [R4]
            next_st.tx_sh  = {1'b1, st.control[`BIT_TB8], i_WDATA}; // [R12]
            next_st.tx_bit = 4'h0;
            next_st.tx_st  = uart_pkg::SHIFT;
         end else if (i_ADDR == `ADDR_BAUD_CTRL) begin
            next_st.baud = i_WDATA[3:0];
         end else if (i_ADDR == `ADDR_RELOAD) begin
            next_st.reload = i_WDATA;
         end else if (i_ADDR == `ADDR_TIMER_LOW) begin
            next_st.tl = i_WDATA;
         end
      end
      // register reads, data one cycle later
      if (i_RD) begin
         if (i_ADDR == `ADDR_CONTROL) begin
            next_st.rdata = st.control | 8'h40; // [R22]
         end else if (i_ADDR == `ADDR_DATA) begin
            next_st.rdata = st.rx_buf; // receive side only [R5]
         end else if (i_ADDR == `ADDR_BAUD_CTRL) begin
            next_st.rdata = {4'h0, st.baud};
         end else if (i_ADDR == `ADDR_RELOAD) begin
            next_st.rdata = st.reload;
         end else if (i_ADDR == `ADDR_TIMER_LOW) begin
            next_st.rdata = st.tl;
         end else begin
            next_st.rdata = 8'h00;
         end
      end
      // interrupt request while enabled and a flag stands [R13]
      next_st.irq = i_IRQ_ENABLE &&
                    (next_st.control[`BIT_TI] || next_st.control[`BIT_RI]);
   end
   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         st         <= '0;
         st.rx_sync <= 2'h3;
         st.rx_prev <= 1'b1;
         st.out     <= 1'b1;
         st.control <= `CONTROL_RESET;
      end else if (i_CE) begin
         st <= next_st;
      end
   end
   assign o_RDATA      = st.rdata;
   assign o_SERIAL_OUT = st.out;
   assign o_IRQ        = st.irq;
   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_unused_bit_one: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      st.control[`BIT_UNUSED]) else $error("unused control bit not one"); // [R22]
   a_line_idle_high: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      st.tx_st == uart_pkg::IDLE |-> o_SERIAL_OUT)
      else $error("serial out not idle high"); // [R24]
   a_data_write_start: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      i_CE && i_WR && i_ADDR == `ADDR_DATA |=> st.tx_st == uart_pkg::SHIFT)
      else $error("data write did not start transmit"); // [R4]
   a_ri_sticky: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      st.control[`BIT_RI] && !(i_WR && i_ADDR == `ADDR_CONTROL) |=> st.control[`BIT_RI])
      else $error("rx done cleared without write"); // [R14]
   a_buf_held: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      st.control[`BIT_RI] |=> $stable(st.rx_buf))
      else $error("buffer overwritten on overrun"); // [R10]
   a_rx_enable: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      st.rx_st == uart_pkg::R_IDLE && !st.control[`BIT_REN] |=> st.rx_st == uart_pkg::R_IDLE)
      else $error("receive started while disabled"); // [R7]
   a_read_data: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      i_CE && i_RD && i_ADDR == `ADDR_DATA |=> o_RDATA == $past(st.rx_buf))
      else $error("data read not receive buffer"); // [R5]
   a_irq_flags: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
      o_IRQ |-> st.control[`BIT_TI] || st.control[`BIT_RI])
      else $error("interrupt without flag"); // [R13]
endmodule
